// ### conv_regs_defs.svh
`ifndef CONV_REGS_DEFS_SVH
`define CONV_REGS_DEFS_SVH

`define CONV_STATUS_ADDR 8'h05
`define NVM_CONTROL_ADDR 8'hff

`define CONV_STATUS_RESET 8'h00
`define NVM_CONTROL_RESET 8'h00

`define THERMAL_TRIP_BIT 7
`define HOT_JUNCTION_BIT 6
`define LIGHT_LOAD_BIT 5
`define CONVERSION_ACTIVE_BIT 4
`define BYPASS_OVERCURRENT_BIT 3
`define BOOST_OVERCURRENT_BIT 2
`define GENERAL_FAULT_BIT 1
`define OUTPUT_IN_REG_BIT 0

`define NVM_WRITE_TRIGGER_BIT 7
`define NVM_LOCK_REQUEST_BIT 6
`define NVM_LOCKED_BIT 5

`define REF_CLK_PERIOD_PS 25000
`define BOOST_ILIM_TIME_US 1500

`endif

// ### conv_regs_pkg.sv
package conv_regs_pkg;
    typedef enum logic [1:0] {
        NVM_IDLE = 2'b00,
        NVM_PROG = 2'b01
    } nvm_state_e;

    typedef logic [7:0] reg_byte_t;
endpackage : conv_regs_pkg

// ### level_sync.sv
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Only the second stage is visible outside; the first stage may be metastable.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : level_sync

// ### status_and_nvm_control_regs.sv
`timescale 1ns/1ps
`include "conv_regs_defs.svh"
module status_and_nvm_control_regs #(
    parameter int BOOST_ILIM_CYCLES =
        (`BOOST_ILIM_TIME_US * 1000000 + `REF_CLK_PERIOD_PS - 1) / `REF_CLK_PERIOD_PS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic reg_rd_done,
    output logic [7:0] reg_rdata,
    input wire logic thermal_trip_in,
    input wire logic hot_junction_in,
    input wire logic light_load_in,
    input wire logic boost_active_in,
    input wire logic bypass_ilim_in,
    input wire logic boost_ilim_in,
    input wire logic fault_in,
    input wire logic out_in_reg_in,
    input wire logic forced_bypass_in,
    input wire logic nvm_lock_stored_in,
    output logic nvm_prog_req,
    output logic nvm_lock_req,
    input wire logic nvm_prog_done
);
    localparam int CNT_W = $clog2(BOOST_ILIM_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(BOOST_ILIM_CYCLES);

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    logic [9:0] pins_s;
    logic thermal_s;
    logic hot_s;
    logic light_s;
    logic boost_s;
    logic bypass_ilim_s;
    logic boost_ilim_s;
    logic fault_s;
    logic in_reg_s;
    logic forced_s;
    logic lock_stored_s;

    level_sync #(.WIDTH(10)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({thermal_trip_in, hot_junction_in, light_load_in, boost_active_in,
                   bypass_ilim_in, boost_ilim_in, fault_in, out_in_reg_in,
                   forced_bypass_in, nvm_lock_stored_in}),
        .sync_out(pins_s)
    );

    assign {thermal_s, hot_s, light_s, boost_s, bypass_ilim_s, boost_ilim_s,
            fault_s, in_reg_s, forced_s, lock_stored_s} = pins_s;

    // Status flags, boost limit timer and read snapshot.
    logic thermal_ff, nxt_thermal;
    logic bypass_oc_ff, nxt_bypass_oc;
    logic boost_oc_ff, nxt_boost_oc;
    logic fault_ff, nxt_fault;
    logic [CNT_W-1:0] ilim_cnt_ff, nxt_ilim_cnt;
    logic [7:0] snap_ff, nxt_snap;
    logic rd_pend_ff, nxt_rd_pend;
    logic boost_limit_met;
    logic [7:0] clr_mask;
    logic [7:0] status_live;

    assign boost_limit_met = (ilim_cnt_ff == CNT_MAX);

    always_comb begin
        status_live = `CONV_STATUS_RESET;
        status_live[`THERMAL_TRIP_BIT] = thermal_ff;
        status_live[`HOT_JUNCTION_BIT] = hot_s;
        status_live[`LIGHT_LOAD_BIT] = light_s;
        status_live[`CONVERSION_ACTIVE_BIT] = boost_s;
        status_live[`BYPASS_OVERCURRENT_BIT] = bypass_oc_ff;
        status_live[`BOOST_OVERCURRENT_BIT] = boost_oc_ff;
        status_live[`GENERAL_FAULT_BIT] = fault_ff;
        status_live[`OUTPUT_IN_REG_BIT] = in_reg_s | forced_s;
    end

    always_comb begin
        nxt_snap = snap_ff;
        nxt_rd_pend = rd_pend_ff;
        clr_mask = 8'h00;
        // Only the bits actually returned are cleared, once the transfer finishes.
        if (reg_rd_done && rd_pend_ff) begin
            clr_mask = snap_ff;
            nxt_rd_pend = 1'b0;
        end
        // A completion that meets a new read still clears, so back-to-back reads lose nothing.
        if (reg_rd_en) begin
            nxt_rd_pend = addr_hit(reg_addr, `CONV_STATUS_ADDR);
        end
        if (reg_rd_en && addr_hit(reg_addr, `CONV_STATUS_ADDR)) begin
            nxt_snap = status_live;
        end
        if (boost_s && boost_ilim_s) begin
            nxt_ilim_cnt = boost_limit_met ? ilim_cnt_ff : ilim_cnt_ff + CNT_W'(1);
        end else begin
            nxt_ilim_cnt = '0;
        end
        // A set in the clearing cycle wins so no event is lost.
        nxt_thermal = (thermal_ff & ~clr_mask[`THERMAL_TRIP_BIT]) | thermal_s;
        nxt_bypass_oc = (bypass_oc_ff & ~clr_mask[`BYPASS_OVERCURRENT_BIT])
                        | bypass_ilim_s;
        nxt_boost_oc = (boost_oc_ff & ~clr_mask[`BOOST_OVERCURRENT_BIT])
                       | boost_limit_met;
        nxt_fault = (fault_ff & ~clr_mask[`GENERAL_FAULT_BIT]) | fault_s;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_ff <= 1'b0;
            bypass_oc_ff <= 1'b0;
            boost_oc_ff <= 1'b0;
            fault_ff <= 1'b0;
            ilim_cnt_ff <= '0;
            snap_ff <= `CONV_STATUS_RESET;
            rd_pend_ff <= 1'b0;
        end else begin
            thermal_ff <= nxt_thermal;
            bypass_oc_ff <= nxt_bypass_oc;
            boost_oc_ff <= nxt_boost_oc;
            fault_ff <= nxt_fault;
            ilim_cnt_ff <= nxt_ilim_cnt;
            snap_ff <= nxt_snap;
            rd_pend_ff <= nxt_rd_pend;
        end
    end

    // Memory control: trigger, lock request, permanent lock and programming sequencer.
    conv_regs_pkg::nvm_state_e state_ff, nxt_state;
    logic wen_ff, nxt_wen;
    logic wp_ff, nxt_wp;
    logic locked_ff, nxt_locked;
    logic prog_req_ff, nxt_prog_req;
    logic lock_req_ff, nxt_lock_req;
    logic nvm_locked;
    logic ctrl_wr;
    logic [7:0] ctrl_read;

    assign nvm_locked = locked_ff | lock_stored_s;
    assign ctrl_wr = reg_wr_en && addr_hit(reg_addr, `NVM_CONTROL_ADDR);

    always_comb begin
        ctrl_read = `NVM_CONTROL_RESET;
        ctrl_read[`NVM_WRITE_TRIGGER_BIT] = wen_ff;
        ctrl_read[`NVM_LOCK_REQUEST_BIT] = wp_ff;
        ctrl_read[`NVM_LOCKED_BIT] = nvm_locked;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_wen = wen_ff;
        nxt_wp = wp_ff;
        nxt_locked = locked_ff | lock_stored_s;
        nxt_prog_req = prog_req_ff;
        nxt_lock_req = lock_req_ff;
        // Bits 4:0 and the status bit are never stored from a write.
        if (ctrl_wr && state_ff == conv_regs_pkg::NVM_IDLE) begin
            nxt_wp = reg_wdata[`NVM_LOCK_REQUEST_BIT];
        end
        case (state_ff)
            conv_regs_pkg::NVM_IDLE: begin
                nxt_wen = 1'b0;
                if (ctrl_wr && reg_wdata[`NVM_WRITE_TRIGGER_BIT] && !nvm_locked) begin
                    nxt_wen = 1'b1;
                    nxt_prog_req = 1'b1;
                    nxt_lock_req = reg_wdata[`NVM_LOCK_REQUEST_BIT];
                    nxt_state = conv_regs_pkg::NVM_PROG;
                end
            end
            conv_regs_pkg::NVM_PROG: begin
                if (nvm_prog_done) begin
                    nxt_wen = 1'b0;
                    nxt_prog_req = 1'b0;
                    nxt_lock_req = 1'b0;
                    nxt_locked = locked_ff | lock_stored_s | lock_req_ff;
                    nxt_state = conv_regs_pkg::NVM_IDLE;
                end
            end
            default: begin
                nxt_wen = 1'b0;
                nxt_prog_req = 1'b0;
                nxt_lock_req = 1'b0;
                nxt_state = conv_regs_pkg::NVM_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= conv_regs_pkg::NVM_IDLE;
            wen_ff <= 1'b0;
            wp_ff <= 1'b0;
            locked_ff <= 1'b0;
            prog_req_ff <= 1'b0;
            lock_req_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wen_ff <= nxt_wen;
            wp_ff <= nxt_wp;
            locked_ff <= nxt_locked;
            prog_req_ff <= nxt_prog_req;
            lock_req_ff <= nxt_lock_req;
        end
    end

    // Read data register; unmapped addresses return zero.
    conv_regs_pkg::reg_byte_t rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd_en) begin
            if (addr_hit(reg_addr, `CONV_STATUS_ADDR)) begin
                nxt_rdata = status_live;
            end else if (addr_hit(reg_addr, `NVM_CONTROL_ADDR)) begin
                nxt_rdata = ctrl_read;
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign nvm_prog_req = prog_req_ff;
    assign nvm_lock_req = lock_req_ff;

    // Read strobes seen by the checks below; the checks look at the returned byte.
    logic st_rd;
    logic ctl_rd;

    assign st_rd = reg_rd_en && addr_hit(reg_addr, `CONV_STATUS_ADDR);
    assign ctl_rd = reg_rd_en && addr_hit(reg_addr, `NVM_CONTROL_ADDR);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_thermal_latch: assert property (thermal_s |=> thermal_ff)
        else $error("thermal trip flag not set by event");
    a_thermal_hold: assert property (thermal_ff && !clr_mask[`THERMAL_TRIP_BIT]
        |=> thermal_ff) else $error("thermal trip flag lost without read");
    a_hot_live: assert property (st_rd |=> reg_rdata[`HOT_JUNCTION_BIT] == $past(hot_s))
        else $error("hot junction flag not live");
    a_mode_bits: assert property (st_rd |=> reg_rdata[5:4] == $past({light_s, boost_s}))
        else $error("mode bits do not follow converter");
    a_bypass_clear: assert property (clr_mask[3] && !bypass_ilim_s |=> !bypass_oc_ff)
        else $error("bypass overcurrent flag not cleared after read");
    a_boost_timer: assert property ($rose(boost_oc_ff) |-> $past(boost_limit_met))
        else $error("boost overcurrent set before time limit");
    a_fault_latch: assert property (fault_s |=> fault_ff)
        else $error("fault flag not latched");
    a_forced_in_reg: assert property (st_rd && forced_s
        |=> reg_rdata[`OUTPUT_IN_REG_BIT])
        else $error("regulation flag not forced in pass-through");
    a_trigger_start: assert property (ctrl_wr && reg_wdata[7] && !nvm_locked
        && state_ff == conv_regs_pkg::NVM_IDLE |=> wen_ff && prog_req_ff)
        else $error("write trigger did not start copy");
    a_trigger_done: assert property (prog_req_ff && nvm_prog_done
        |=> !wen_ff && !prog_req_ff) else $error("write trigger not self-cleared");
    a_lock_after: assert property (lock_req_ff && nvm_prog_done |=> ##1 ctrl_read[5])
        else $error("lock not taken after copy");
    a_lock_perm: assert property (locked_ff |=> locked_ff)
        else $error("memory lock was undone");
    a_locked_reject: assert property (nvm_locked |=> !$rose(prog_req_ff))
        else $error("copy started while locked");
    a_reserved_zero: assert property (ctl_rd |=> reg_rdata[4:0] == 5'h00)
        else $error("reserved control bits not zero");
    a_read_clear: assert property (rd_pend_ff && reg_rd_done && !fault_s
        && snap_ff[1] |=> !fault_ff) else $error("fault flag not cleared after read");

    c_status_read: cover property (reg_rd_en && addr_hit(reg_addr, `CONV_STATUS_ADDR)
        ##[1:20] reg_rd_done);
    c_boost_trip: cover property ($rose(boost_oc_ff));
    c_nvm_copy: cover property ($rose(prog_req_ff) ##[1:100] $fell(prog_req_ff));
    c_nvm_lock: cover property ($rose(locked_ff));
endmodule : status_and_nvm_control_regs

// ### nvm_engine_model.sv
`timescale 1ns/1ps
module nvm_engine_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic prog_req,
    input wire logic lock_req,
    input wire logic [7:0] delay,
    output logic prog_done,
    output logic lock_stored
);
    logic [7:0] cnt_ff;
    // The copy takes delay plus one cycles, so the bench can make the engine prompt or slow.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            prog_done <= 1'b0;
        end else if (prog_req && !prog_done && cnt_ff == delay) begin
            cnt_ff <= 8'h00;
            prog_done <= 1'b1;
        end else begin
            cnt_ff <= (prog_req && !prog_done) ? cnt_ff + 8'h01 : 8'h00;
            prog_done <= 1'b0;
        end
    end
    // The lock is kept in storage, so a reset of the register logic must not lose it.
    logic stored_ff = 1'b0;
    always @(posedge ref_clk) begin
        if (prog_req && prog_done && lock_req) begin
            stored_ff <= 1'b1;
        end
    end
    assign lock_stored = stored_ff;
endmodule : nvm_engine_model

// ### status_and_nvm_control_regs_bench.sv
`timescale 1ns/1ps
`include "conv_regs_defs.svh"
module status_and_nvm_control_regs_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd_en = 1'b0;
    logic reg_rd_done = 1'b0;
    logic [7:0] reg_rdata;
    logic [8:0] cond = 9'h000;
    logic nvm_prog_req, nvm_lock_req, nvm_prog_done, lock_stored;
    logic [7:0] delay = 8'h00;
    logic [7:0] val;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int b_list[4] = '{6, 5, 4, 0};

    always #12.5 ref_clk = ~ref_clk;

    status_and_nvm_control_regs #(.BOOST_ILIM_CYCLES(10)) status_and_nvm_control_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rd_done(reg_rd_done),
        .reg_rdata(reg_rdata), .thermal_trip_in(cond[7]), .hot_junction_in(cond[6]),
        .light_load_in(cond[5]), .boost_active_in(cond[4]), .bypass_ilim_in(cond[3]),
        .boost_ilim_in(cond[2]), .fault_in(cond[1]), .out_in_reg_in(cond[0]),
        .forced_bypass_in(cond[8]), .nvm_lock_stored_in(lock_stored),
        .nvm_prog_req(nvm_prog_req), .nvm_lock_req(nvm_lock_req),
        .nvm_prog_done(nvm_prog_done));

    nvm_engine_model nvm_engine_model_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .prog_req(nvm_prog_req), .lock_req(nvm_lock_req),
        .delay(delay), .prog_done(nvm_prog_done), .lock_stored(lock_stored));

    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : tick

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        tick(1);
        reg_wr_en = 1'b0;
    endtask : wr

    // Every read is closed by its completion pulse, which is what clears sticky flags.
    task automatic rd(input logic [7:0] a);
        tick(1);
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick(1);
        reg_rd_en = 1'b0;
        val = reg_rdata;
        reg_rd_done = 1'b1;
        tick(1);
        reg_rd_done = 1'b0;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk8(val, exp);
    endtask : rdc

    // Busy and finished values are fixed; only the moment of completion is left open.
    task automatic wait_copy(input logic [7:0] busy, input logic [7:0] done);
        int i;
        val = 8'h80;
        for (i = 0; i < 60 && val[7]; i++) begin
            rd(`NVM_CONTROL_ADDR);
            chk8(val, val[7] ? busy : done);
        end
        chk1(val[7], 1'b0);
    endtask : wait_copy

    initial begin
        int b;
        tick(12);
        rst_n = 1'b1;
        tick(3);
        rdc(`CONV_STATUS_ADDR, 8'h00);
        rdc(`NVM_CONTROL_ADDR, 8'h00);
        rdc(8'h33, 8'h00);
        foreach (b_list[k]) begin
            cond = 9'h001 << b_list[k];
            tick(4);
            rdc(`CONV_STATUS_ADDR, 8'(cond));
        end
        cond = 9'h100;
        tick(4);
        rdc(`CONV_STATUS_ADDR, 8'h01);
        for (b = 7; b > 0; b -= 2) begin
            if (b == 5) b = 3;
            cond = 9'h001 << b;
            tick(3);
            cond = 9'h000;
            tick(4);
            rdc(`CONV_STATUS_ADDR, 8'h01 << b);
            rdc(`CONV_STATUS_ADDR, 8'h00);
        end
        cond = 9'h002;
        tick(4);
        rdc(`CONV_STATUS_ADDR, 8'h02);
        rdc(`CONV_STATUS_ADDR, 8'h02);
        cond = 9'h004;
        tick(20);
        rdc(`CONV_STATUS_ADDR, 8'h02);
        cond = 9'h014;
        tick(8);
        cond = 9'h010;
        tick(3);
        rdc(`CONV_STATUS_ADDR, 8'h10);
        cond = 9'h014;
        tick(14);
        cond = 9'h000;
        tick(4);
        rdc(`CONV_STATUS_ADDR, 8'h04);
        rdc(`CONV_STATUS_ADDR, 8'h00);
        wr(`CONV_STATUS_ADDR, 8'hff);
        rdc(`CONV_STATUS_ADDR, 8'h00);
        wr(`NVM_CONTROL_ADDR, 8'h1f);
        tick(1);
        chk1(nvm_prog_req, 1'b0);
        rdc(`NVM_CONTROL_ADDR, 8'h00);
        delay = 8'h14;
        wr(`NVM_CONTROL_ADDR, 8'h80);
        tick(1);
        chk1(nvm_prog_req, 1'b1);
        chk1(nvm_lock_req, 1'b0);
        rdc(`NVM_CONTROL_ADDR, 8'h80);
        wait_copy(8'h80, 8'h00);
        rdc(`NVM_CONTROL_ADDR, 8'h00);
        delay = 8'h00;
        wr(`NVM_CONTROL_ADDR, 8'hc0);
        tick(1);
        chk1(nvm_prog_req, 1'b1);
        chk1(nvm_lock_req, 1'b1);
        wait_copy(8'hc0, 8'h60);
        rdc(`NVM_CONTROL_ADDR, 8'h60);
        wr(`NVM_CONTROL_ADDR, 8'h80);
        tick(2);
        chk1(nvm_prog_req, 1'b0);
        wr(`NVM_CONTROL_ADDR, 8'h00);
        rdc(`NVM_CONTROL_ADDR, 8'h20);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(4);
        rdc(`NVM_CONTROL_ADDR, 8'h20);
        give_verdict();
    end
endmodule : status_and_nvm_control_regs_bench
